// File: logic/scfr_top.sv
`timescale 1ns/1ps
`default_nettype none
// serial command decoder and fault reporter
module scfr_top
  import scfr_pkg::*;
#(
  parameter int N_OUT    = 8,
  parameter int SC_LIMIT = SC_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  input  wire logic              spi_sclk,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  output logic                   spi_miso_oe,
  input  wire logic              ov_pin,
  input  wire logic [9:0]        oc_pin,
  input  wire logic [9:0]        thermal_pin,
  input  wire logic [7:0]        off_open_load_pin,
  input  wire logic [1:0]        ccd_on_open_load_pin,
  input  wire logic [5:0]        gd_fault_pin,
  input  wire logic [1:0]        ccd_active,
  output logic      [7:0]        low_side_switch_outputs,
  output logic      [9:0]        current_limit,
  output logic                   supply_overvoltage_flag
);
  localparam int N_LIM  = N_OUT + 2;  // low-side plus two current drivers
  localparam int SYNC_W = 40;

  // status layout is fixed at eight low-side outputs
  if (N_OUT != 8) begin : g_bad_n_out
    $error("scfr_top: N_OUT must be 8");
  end
  if (SC_LIMIT < 1 || SC_LIMIT >= (1 << CNT_W)) begin : g_bad_sc
    $error("scfr_top: SC_LIMIT out of range");
  end

  // synchronised pin levels
  logic [SYNC_W-1:0] pins_lvl;
  logic              sclk_lvl;
  logic              cs_lvl;
  logic              mosi_lvl;
  logic              ov_lvl;
  logic [9:0]        oc_lvl;
  logic [9:0]        therm_lvl;
  logic [7:0]        off_ol_lvl;
  logic [1:0]        ccd_ol_lvl;
  logic [5:0]        gd_lvl;

  // every pin except ccd_active crosses in one synchroniser bank
  scfr_sync #(
    .W         (SYNC_W),
    .RESET_VAL (40'h00_0000_0002)
  ) u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_in    ({gd_fault_pin, ccd_on_open_load_pin, off_open_load_pin,
                 thermal_pin, oc_pin, ov_pin, spi_mosi, spi_cs_n, spi_sclk}),
    .level_out (pins_lvl)
  );
  assign {gd_lvl, ccd_ol_lvl, off_ol_lvl, therm_lvl, oc_lvl,
          ov_lvl, mosi_lvl, cs_lvl, sclk_lvl} = pins_lvl;

  // edge history of link signals
  logic sclk_prev;
  logic cs_prev;
  logic ov_prev;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;  // idle high, no false frame
      ov_prev   <= 1'b0;
    end else begin
      sclk_prev <= sclk_lvl;
      cs_prev   <= cs_lvl;
      ov_prev   <= ov_lvl;
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic ov_fall;
  assign sclk_rise = sclk_lvl & ~sclk_prev;
  assign sclk_fall = ~sclk_lvl & sclk_prev;
  assign cs_fall   = ~cs_lvl & cs_prev;
  assign cs_rise   = cs_lvl & ~cs_prev;
  assign ov_fall   = ~ov_lvl & ov_prev;

  // frame engine state
  scfr_frame_e       state;
  logic [4:0]        bit_cnt;    // saturates, catches long frames
  logic [15:0]       shift_in;   // command word, msb first
  logic [15:0]       shift_out;  // status word being sent
  logic [CNT_W-1:0]  low_cnt;    // chip select low time
  logic [15:0]       status_word;
  logic              exec_reg;   // one cycle: good frame ended
  logic              bad_len;
  logic              cal_done;
  logic              cal_armed;
  logic [4:0]        code;
  assign code = shift_in[CODE_HI:CODE_LO];

  // command registers
  logic [7:0]        oss_cmd;
  logic [7:0]        ov_retry;
  logic [7:0]        therm_en;
  logic [7:0]        sc_off;     // outputs tripped by short circuit
  logic [N_LIM-1:0]  trip;
  // fault latches
  logic [7:0]        out_flt;
  logic [5:0]        gd_flt;
  logic [1:0]        ccd_flt;
  logic              sys_flt;
  logic              por_flag;
  logic              cal_flt_ev;
  logic [CNT_W-1:0]  cal_count;
  // software side
  logic [CTRL_W-1:0] ctrl_reg;
  logic [EV_W-1:0]   ev_reg;
  logic [EV_W-1:0]   mask_reg;

  // snapshot layout; message select swaps the middle field
  assign status_word = {sys_flt, por_flag,
                        ctrl_reg[CTRL_MSG_SEL] ? {4'h0, ccd_flt} : gd_flt,
                        out_flt};

  // serial frame engine, mode 0: sample on rise, shift on fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state       <= F_IDLE;
      bit_cnt     <= 5'h00;
      shift_in    <= 16'h0000;
      shift_out   <= 16'h0000;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
      low_cnt     <= 16'h0000;
    end else begin
      unique case (state)
        F_IDLE: begin
          if (cs_fall) begin
            state       <= F_SHIFT;
            bit_cnt     <= 5'h00;
            low_cnt     <= 16'h0000;
            shift_out   <= status_word;
            spi_miso    <= status_word[15];
            spi_miso_oe <= 1'b1;
          end
        end
        F_SHIFT: begin
          if (low_cnt != '1) begin
            low_cnt <= low_cnt + 16'h0001;
          end
          if (cs_rise) begin
            state       <= F_IDLE;
            spi_miso_oe <= 1'b0;
          end else if (sclk_rise) begin
            shift_in <= {shift_in[14:0], mosi_lvl};
            if (bit_cnt != '1) begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end else if (sclk_fall) begin
            shift_out <= {shift_out[14:0], 1'b0};
            spi_miso  <= shift_out[14];
          end
        end
      endcase
    end
  end

  // end of frame: execute only a full sixteen-bit word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exec_reg <= 1'b0;
      bad_len  <= 1'b0;
      cal_done <= 1'b0;
    end else begin
      exec_reg <= (state == F_SHIFT) && cs_rise && bit_cnt == FRAME_LEN;
      // a clockless low pulse while armed is the calibration pulse
      cal_done <= (state == F_SHIFT) && cs_rise && cal_armed && bit_cnt == 5'h00;
      bad_len  <= (state == F_SHIFT) && cs_rise && bit_cnt != FRAME_LEN
                  && !(cal_armed && bit_cnt == 5'h00);
    end
  end

  // calibration: arm on command, measure next clockless pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_armed  <= 1'b0;
      cal_count  <= 16'h0000;
      cal_flt_ev <= 1'b0;
    end else begin
      cal_flt_ev <= 1'b0;
      if (exec_reg && code == CMD_RESET) begin
        cal_armed <= 1'b0;
      end else if (exec_reg && code == CMD_CALIBRATE) begin
        cal_armed <= 1'b1;
      end else if (cal_done) begin
        cal_armed  <= 1'b0;
        cal_count  <= low_cnt;
        cal_flt_ev <= (low_cnt < CAL_MIN) || (low_cnt > CAL_MAX);
      end
    end
  end

  // output on/off register with over-voltage recovery
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oss_cmd <= OSS_POR;
    end else if (exec_reg && code == CMD_RESET) begin
      oss_cmd <= OSS_POR;
    end else if (exec_reg && code == CMD_OSS_SWITCH) begin
      oss_cmd <= shift_in[7:0];
    end else if (ov_fall) begin
      // retry keeps the old state, shutdown clears it
      oss_cmd <= oss_cmd & ov_retry;
    end
  end

  // retry and thermal enable command registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ov_retry <= OV_RETRY_POR;
      therm_en <= THERM_EN_POR;
    end else if (exec_reg && code == CMD_RESET) begin
      ov_retry <= OV_RETRY_POR;
      therm_en <= THERM_EN_POR;
    end else if (exec_reg && code == CMD_OV_RETRY) begin
      ov_retry <= shift_in[7:0];
    end else if (exec_reg && code == CMD_THERM_EN) begin
      therm_en <= shift_in[7:0];
    end
  end

  // short-circuit shutdown latch, cleared by a new on/off command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sc_off <= 8'h00;
    end else if (exec_reg && (code == CMD_RESET || code == CMD_OSS_SWITCH)) begin
      sc_off <= 8'h00;
    end else begin
      sc_off <= sc_off | trip[7:0];
    end
  end

  // driven outputs: all off during over-voltage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_side_switch_outputs <= 8'h00;
      supply_overvoltage_flag <= 1'b0;
    end else begin
      // stay off in the recovery cycle too, before retry masks the on/off register
      low_side_switch_outputs <= (ov_lvl || ov_fall) ? 8'h00 : (oss_cmd & ~sc_off);
      supply_overvoltage_flag <= ov_lvl;
    end
  end

  // current limit per channel: timer, or thermal when enabled
  logic [N_LIM-1:0] on_vec;
  logic [N_LIM-1:0] th_sel;
  assign on_vec = {ccd_active, low_side_switch_outputs};
  assign th_sel = {{2{ctrl_reg[CTRL_CCD_THERM]}}, therm_en};
  generate
    for (genvar i = 0; i < N_LIM; i++) begin : g_lim
      logic [CNT_W-1:0] lim_cnt;  // cycles spent limiting
      logic             tripped;  // held until over-current clears or the channel turns off
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          lim_cnt          <= 16'h0000;
          tripped          <= 1'b0;
          trip[i]          <= 1'b0;
          current_limit[i] <= 1'b0;
        end else begin
          trip[i] <= 1'b0;
          if (!oc_lvl[i] || !on_vec[i]) begin
            lim_cnt          <= 16'h0000;
            tripped          <= 1'b0;
            current_limit[i] <= 1'b0;
          end else if (!tripped) begin
            if (th_sel[i] ? therm_lvl[i] : lim_cnt == 16'(SC_LIMIT - 1)) begin
              tripped          <= 1'b1;
              trip[i]          <= 1'b1;
              current_limit[i] <= 1'b0;
            end else begin
              lim_cnt          <= lim_cnt + 16'h0001;
              current_limit[i] <= 1'b1;
            end
          end
        end
      end
      sc_window_a: assert property (@(posedge clk) disable iff (!rst_n)
        current_limit[i] && !th_sel[i] |-> lim_cnt < 16'(SC_LIMIT))
        else $error("limit held past short circuit window");
    end
  endgenerate

  // fault events; gate drivers have no on-state open-load input
  logic [7:0] oc_ev;
  logic [7:0] off_ol_ev;
  logic [1:0] ccd_ev;
  assign oc_ev     = oc_lvl[7:0] & oss_cmd;
  assign off_ol_ev = off_ol_lvl & ~oss_cmd;
  assign ccd_ev    = (oc_lvl[9:8] | ccd_ol_lvl) & ccd_active;

  // snapshot or reset command clears every sticky fault latch
  logic flt_clr;
  assign flt_clr = (state == F_IDLE && cs_fall) || (exec_reg && code == CMD_RESET);

  // sticky fault latches, set wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_flt <= 8'h00;
      gd_flt  <= 6'h00;
      ccd_flt <= 2'h0;
      sys_flt <= 1'b0;
    end else begin
      out_flt <= (flt_clr ? 8'h00 : out_flt) | oc_ev | off_ol_ev;
      gd_flt  <= (flt_clr ? 6'h00 : gd_flt) | gd_lvl;
      ccd_flt <= (flt_clr ? 2'h0 : ccd_flt) | ccd_ev;
      sys_flt <= (flt_clr ? 1'b0 : sys_flt)
                 | ov_lvl | cal_flt_ev | (|(trip & th_sel));
    end
  end

  // power-on indicator: only a true reset sets it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      por_flag <= 1'b1;
    end else if (state == F_IDLE && cs_fall) begin
      por_flag <= 1'b0;
    end
  end

  // avalon slave: one wait cycle, then the answer
  logic req;
  assign req = avs_read | avs_write;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  // read mux, loaded at the same edge where waitrequest falls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        A_CTRL:      avs_readdata <= {30'h0, ctrl_reg};
        A_EVENT:     avs_readdata <= {27'h0, ev_reg};
        A_MASK:      avs_readdata <= {27'h0, mask_reg};
        A_LAST_CMD:  avs_readdata <= {16'h0, shift_in};
        A_OUT_STATE: avs_readdata <= {6'h0, current_limit, out_flt,
                                      low_side_switch_outputs};
        A_CAL:       avs_readdata <= {16'h0, cal_count};
        default:     avs_readdata <= 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // writes land at the edge where waitrequest is seen low
  logic wr_go;
  assign wr_go = avs_write && !avs_waitrequest;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_POR;
      mask_reg <= 5'h00;
    end else if (wr_go && avs_address == A_CTRL) begin
      ctrl_reg <= avs_writedata[CTRL_W-1:0];
    end else if (wr_go && avs_address == A_MASK) begin
      mask_reg <= avs_writedata[EV_W-1:0];
    end
  end

  // event status: write one to clear, a new event wins
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  assign ev_set = {bad_len, cal_done, ov_lvl & ~ov_prev,
                   exec_reg && code == CMD_RESET, exec_reg};
  assign ev_clr = (wr_go && avs_address == A_EVENT) ? avs_writedata[EV_W-1:0]
                                                    : 5'h00;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_reg <= 5'h00;
      irq    <= 1'b0;
    end else begin
      ev_reg <= (ev_reg & ~ev_clr) | ev_set;
      irq    <= |(ev_reg & mask_reg);
    end
  end

  // checks on the frame engine and command effects
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  snap_msb_a: assert property (
    state == F_IDLE && cs_fall |=> spi_miso == $past(status_word[15]) && spi_miso_oe)
    else $error("first status bit not msb");
  snap_word_a: assert property (
    state == F_IDLE && cs_fall |=> shift_out == $past(status_word))
    else $error("status snapshot wrong");
  frame_len_a: assert property (
    exec_reg |-> $past(bit_cnt) == FRAME_LEN && state == F_IDLE)
    else $error("command executed on short frame");
  reset_cmd_a: assert property (
    exec_reg && code == CMD_RESET |=> oss_cmd == OSS_POR && ov_retry == OV_RETRY_POR
      && therm_en == THERM_EN_POR && sc_off == 8'h00 && !cal_armed
      && out_flt == ($past(oc_ev) | $past(off_ol_ev)) && gd_flt == $past(gd_lvl))
    else $error("reset command left state");
  nop_hold_a: assert property (
    exec_reg && (code == CMD_NOP_ONES || code == CMD_NOP_ZEROS) && !ov_fall
      |=> $stable(oss_cmd) && $stable(ov_retry) && $stable(therm_en) && $stable(cal_armed))
    else $error("no-operation changed a register");
  oss_drive_a: assert property (
    exec_reg && code == CMD_OSS_SWITCH && !ov_lvl ##1 !ov_lvl && trip == '0
      |=> low_side_switch_outputs == $past(shift_in[7:0], 2))
    else $error("outputs do not follow command");
  oc_report_a: assert property (
    |oc_ev |=> (out_flt & $past(oc_ev)) == $past(oc_ev))
    else $error("over-current not latched");
  off_ol_a: assert property (
    |off_ol_ev |=> (out_flt & $past(off_ol_ev)) == $past(off_ol_ev))
    else $error("off-state open load not latched");
  ccd_ol_a: assert property (
    |ccd_ev |=> (ccd_flt & $past(ccd_ev)) == $past(ccd_ev))
    else $error("driver open load not latched");
  ov_off_a: assert property (
    ov_lvl |=> low_side_switch_outputs == 8'h00)
    else $error("output on during over-voltage");
  ov_retry_a: assert property (
    ov_fall && !exec_reg |=> oss_cmd == ($past(oss_cmd) & $past(ov_retry)))
    else $error("recovery ignored retry setting");
  por_flag_a: assert property (
    $past(por_flag) && !($past(state) == F_IDLE && $past(cs_fall)) |-> por_flag)
    else $error("reset indicator lost before frame");

  frame_c:   cover property (exec_reg && code == CMD_OSS_SWITCH);
  rst_cmd_c: cover property (exec_reg && code == CMD_RESET);
  ov_rec_c:  cover property (ov_fall);
  cal_c:     cover property (cal_done);
endmodule : scfr_top
`default_nettype wire

// File: include/scfr_pkg.sv
// What this block does
// - reset command restores all command register power-on defaults
// - both no-operation codes change nothing
// - each frame: sixteen bits in, sixteen out
// - command and status shift msb first
// - command bit zero off, one on
// - status bit one means fault present
// - over-current reported in output fault bit
// - on-state open load only for current drivers
// - off-state open load reported per output
// - over-voltage stops outputs, recovery per retry
// - current limit until timer or thermal
// - calibration pulse on chip select measured
// - status carries power-on reset indicator
// - retry bit zero shutdown, one resume
package scfr_pkg;
  // clock and timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int CLK_MHZ      = CLK_HZ / 1_000_000;
  localparam int SC_TIME_NS   = 100_000;  // short circuit window
  localparam int SC_CYCLES    = (SC_TIME_NS * CLK_MHZ) / 1000;
  localparam int CAL_PULSE_NS = 32_000;   // nominal calibration pulse
  localparam int CAL_CYCLES   = (CAL_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 16;
  localparam logic [CNT_W-1:0] CAL_MIN = 16'(CAL_CYCLES - CAL_CYCLES / 4);
  localparam logic [CNT_W-1:0] CAL_MAX = 16'(CAL_CYCLES + CAL_CYCLES / 4);
  // frame layout
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam int CODE_HI = 15;
  localparam int CODE_LO = 11;
  localparam int ST_SYS  = 15;  // over-voltage, thermal or calibration
  localparam int ST_POR  = 14;  // power-on reset indicator
  // command codes in the top five bits
  localparam logic [4:0] CMD_NOP_ZEROS  = 5'h00;
  localparam logic [4:0] CMD_OSS_SWITCH = 5'h01;
  localparam logic [4:0] CMD_OV_RETRY   = 5'h03;
  localparam logic [4:0] CMD_THERM_EN   = 5'h05;
  localparam logic [4:0] CMD_CALIBRATE  = 5'h1a;
  localparam logic [4:0] CMD_RESET      = 5'h1b;
  localparam logic [4:0] CMD_NOP_ONES   = 5'h1f;
  // power-on values of command registers
  localparam logic [7:0] OSS_POR      = 8'h00;
  localparam logic [7:0] OV_RETRY_POR = 8'hff;
  localparam logic [7:0] THERM_EN_POR = 8'hff;
  // avalon register map, byte addresses
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] A_CTRL      = 5'h00;
  localparam logic [ADDR_W-1:0] A_EVENT     = 5'h04;
  localparam logic [ADDR_W-1:0] A_MASK      = 5'h08;
  localparam logic [ADDR_W-1:0] A_LAST_CMD  = 5'h0c;
  localparam logic [ADDR_W-1:0] A_OUT_STATE = 5'h10;
  localparam logic [ADDR_W-1:0] A_CAL       = 5'h14;
  // control bits
  localparam int CTRL_W         = 2;
  localparam int CTRL_MSG_SEL   = 0;
  localparam int CTRL_CCD_THERM = 1;
  localparam logic [CTRL_W-1:0] CTRL_POR = 2'h0;
  // event bits
  localparam int EV_W      = 5;
  localparam int EV_FRAME  = 0;
  localparam int EV_RSTCMD = 1;
  localparam int EV_OV     = 2;
  localparam int EV_CAL    = 3;
  localparam int EV_BADLEN = 4;
  // frame states
  typedef enum logic [1:0] {
    F_IDLE  = 2'b01,
    F_SHIFT = 2'b10
  } scfr_frame_e;
endpackage : scfr_pkg

// File: logic/scfr_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser with agreement filter
module scfr_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_reg;  // metastability catcher, read by s2 only
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      // one chain per pin; level moves only when s2 and s3 agree
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_reg[i]    <= RESET_VAL[i];
          s2_reg[i]    <= RESET_VAL[i];
          s3_reg[i]    <= RESET_VAL[i];
          level_out[i] <= RESET_VAL[i];
        end else begin
          s1_reg[i] <= pin_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            level_out[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate
endmodule : scfr_sync
`default_nettype wire

// File: tb/scfr_host.sv
`timescale 1ns/1ps
`default_nettype none
// spi host model: mode 0, sclk idle low, 400 ns bit period
module scfr_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // n rising edges after h cycles of cs low; n = 0 gives a bare cs pulse
  task automatic xfer(input logic [15:0] c, input int n, input int h,
                      output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (h) @(posedge clk);
    for (int i = 15; i > 15 - n; i--) begin
      mosi <= c[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      // late in the high phase, miso is settled long before the next fall
      r = {r[14:0], miso};
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi; // released line must not look valid
    repeat (12) @(posedge clk);
  endtask : xfer
endmodule : scfr_host
`default_nettype wire

// File: tb/tb_scfr_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_scfr_top
  import scfr_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, irq, spi_sclk, spi_cs_n, spi_mosi, spi_miso, ov_flag, miso_oe;
  logic        ov_pin = 1'b0;
  logic [9:0]  oc_pin = 10'h0, thermal_pin = 10'h0, current_limit;
  logic [7:0]  off_ol = 8'h0, outs;
  logic [1:0]  ccd_ol = 2'h0, ccd_active = 2'h0;
  logic [5:0]  gd_fault = 6'h0;
  logic [15:0] rsp;
  int          miscompares = 0, cmp_count = 0;
  // ordinary frames: command word and resulting output drive
  logic [15:0] row_cmd [5] = '{16'h08a5, 16'hf8ff, 16'h005a, 16'h083c, 16'hd8ff};
  logic [7:0]  row_out [5] = '{8'ha5, 8'ha5, 8'ha5, 8'h3c, 8'h00};
  always #25 clk = ~clk;
  scfr_top #(.N_OUT(8), .SC_LIMIT(20)) scfr_top_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(miso_oe),
    .ov_pin(ov_pin), .oc_pin(oc_pin), .thermal_pin(thermal_pin),
    .off_open_load_pin(off_ol), .ccd_on_open_load_pin(ccd_ol),
    .gd_fault_pin(gd_fault), .ccd_active(ccd_active),
    .low_side_switch_outputs(outs), .current_limit(current_limit),
    .supply_overvoltage_flag(ov_flag));
  scfr_host scfr_host_inst (.clk(clk), .sclk(spi_sclk), .cs_n(spi_cs_n),
    .mosi(spi_mosi), .miso(spi_miso));
  // single compare for every result kind
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // avalon access; waits on waitrequest, no fixed latency assumed
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task automatic fr(input logic [15:0] c, input int n);
    scfr_host_inst.xfer(c, n, 8, rsp);
  endtask : fr
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // watchdog: whole run is well under 40k cycles
  initial begin
    #2_000_000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(avs_waitrequest, 1'b1);
    chk({miso_oe, irq, outs}, 10'h000);
    fr(16'h0000, 16);
    chk(rsp, 16'h4000);
    chk(miso_oe, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      fr(row_cmd[i], 16);
      chk(outs, row_out[i]);
    end
    fr(16'h0000, 16);
    chk(rsp, 16'h0000);
    $display("test rows done");
    // over-current on an on output, open load on an off output
    // thermal limit is on after reset; switch to the timer first
    fr(16'h2800, 16);
    fr(16'h0801, 16);
    oc_pin <= 10'h001;
    off_ol <= 8'h02;
    repeat (10) @(posedge clk);
    chk(current_limit[0], 1'b1);
    repeat (30) @(posedge clk);
    chk(outs[0], 1'b0);
    oc_pin <= 10'h000;
    off_ol <= 8'h00;
    repeat (10) @(posedge clk);
    fr(16'hf800, 16);
    chk(rsp, 16'h0003);
    fr(16'hf800, 16);
    chk(rsp, 16'h0000);
    // driver on-state open load shows with driver message selected
    av(1'b1, A_CTRL, 32'h1);
    ccd_active <= 2'b10;
    ccd_ol <= 2'b10;
    repeat (10) @(posedge clk);
    ccd_ol <= 2'b00;
    fr(16'h0000, 16);
    chk(rsp, 16'h0200);
    $display("test faults done");
    // short frame refused, interrupt set, masked path, cleared
    av(1'b1, A_MASK, 32'h10);
    fr(16'h08ff, 15);
    chk(outs, 8'h00);
    chk(irq, 1'b1);
    av(1'b1, A_EVENT, 32'h1f);
    av(1'b0, A_EVENT, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    av(1'b0, 5'h1c, 32'h0);
    chk(q, 32'h0);
    $display("test events done");
    // over-voltage shutdown and partial retry
    fr(16'h080f, 16);
    fr(16'h1805, 16);
    ov_pin <= 1'b1;
    repeat (10) @(posedge clk);
    chk({ov_flag, outs}, 9'h100);
    ov_pin <= 1'b0;
    repeat (10) @(posedge clk);
    chk(outs, 8'h05);
    // calibration command then a bare 644-cycle cs pulse
    fr(16'hd000, 16);
    scfr_host_inst.xfer(16'h0000, 0, 640, rsp);
    av(1'b0, A_EVENT, 32'h0);
    chk(q & 32'h08, 32'h08);
    av(1'b0, A_LAST_CMD, 32'h0);
    chk(q, 32'h0000_d000);
    $display("test ov and calibration done");
    // mid-run reset: outputs off, indicator back in the next status
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({miso_oe, irq, outs}, 10'h000);
    fr(16'h0000, 16);
    chk(rsp, 16'h4000);
    $display("test mid reset done");
    finish_test();
  end
endmodule : tb_scfr_top
`default_nettype wire
